//--- src/crm_command_response_framer.sv
// Command receiver, register access and tri-level response transmitter with an APB slave.
// Assumes command bits arrive synchronous to pclk, one per cmd_bit_valid pulse.
//
// Overview of operation
// - One master exchanges packets with one addressed slave to read or write registers.
// - Commands act only when their address equals the configured address.
// - CRC check covers all 32 command bits, fed most significant first.
// - The check starts from an all-ones seed, then shifts message and CRC.
// - Zero remainder after the last CRC bit means valid, otherwise failure.
// - Command polynomial is a programmable register defaulting to 0x2f.
// - Response is address, code, upper byte, lower byte, CRC: 32 bits.
// - Response address field carries the configured address.
// - Response code field echoes the received command code.
// - For reads and writes, upper byte is register at address plus one, lower byte at address; code b returns zero.
// - Response CRC covers the message, most significant bit first.
// - Response CRC is seed, 24 message bits, then eight zero bits.
// - Response polynomial is a separate register, default 0x2f, seed all ones.
// - Each response nibble is sent as one three-chip symbol.
// - Chips take level 0, 1 or 2 response current steps.
// - Nibbles map to the fixed sixteen-entry chip table.
// - Each symbol starts non-quiescent and holds at least one level change.
// - Code 0 reads, 8 writes, b enters periodic collection; others ignored.
// - Reads to other addresses, including global zero, are ignored.
// - Reads of unreadable registers return zero data.
`timescale 1ns/1ns
`default_nettype none
`include "crm_framer_regs.svh"

module crm_command_response_framer
  import crm_framer_pkg::*;
#(
  parameter int CHIP_CYCLES = `CHIP_CYCLES_DEF,
  parameter int MEM_DEPTH   = `MEM_DEPTH_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        cmd_start,
  input  wire logic        cmd_bit_valid,
  input  wire logic        cmd_bit,
  output var  logic [1:0]  chip_level,
  output var  logic        resp_active,
  output var  logic        crc_error,
  output var  logic        periodic_collection_mode
);

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b,
                                          input logic [7:0] poly);
    crc_step = {c[6:0], b} ^ (c[7] ? poly : 8'h00);
  endfunction

  function automatic logic [5:0] symbol_of(input logic [3:0] n);
    case (n)
      4'h0: symbol_of = 6'h14;
      4'h1: symbol_of = 6'h25;
      4'h2: symbol_of = 6'h12;
      4'h3: symbol_of = 6'h22;
      4'h4: symbol_of = 6'h10;
      4'h5: symbol_of = 6'h26;
      4'h6: symbol_of = 6'h16;
      4'h7: symbol_of = 6'h21;
      4'h8: symbol_of = 6'h28;
      4'h9: symbol_of = 6'h24;
      4'ha: symbol_of = 6'h1a;
      4'hb: symbol_of = 6'h29;
      4'hc: symbol_of = 6'h18;
      4'hd: symbol_of = 6'h20;
      4'he: symbol_of = 6'h11;
      default: symbol_of = 6'h19;
    endcase
  endfunction

  logic [3:0]  address_config_register;
  logic [7:0]  cmd_poly_register;
  logic [7:0]  resp_poly_register;
  logic        crc_err_sticky;
  logic [7:0]  mem [MEM_DEPTH];
  logic [31:0] rx_frame;
  logic [7:0]  rx_crc;
  logic [4:0]  rx_cnt;
  logic        rx_open;
  logic        rx_done;
  tx_state_t   state;
  logic [3:0]  tx_cmd;
  logic [7:0]  register_byte_address;
  logic [31:0] tx_frame;
  logic [7:0]  tx_crc;
  logic [4:0]  tx_cnt;
  logic [2:0]  nib_idx;
  logic [1:0]  chip_idx;
  logic [7:0]  chip_div;

  // command fields as sent by the master.
  cmd_frame_t  cmd;
  resp_frame_t resp;
  assign cmd = cmd_frame_t'(rx_frame);

  wire        apb_acc     = psel && penable && !pready;
  wire        apb_done    = psel && penable && pready;
  wire        sel_addr    = paddr == `OFS_ADDR_CFG;
  wire        sel_cpoly   = paddr == `OFS_CMD_POLY;
  wire        sel_rpoly   = paddr == `OFS_RESP_POLY;
  wire        sel_status  = paddr == `OFS_STATUS;
  wire        mapped      = sel_addr || sel_cpoly || sel_rpoly || sel_status;
  wire        wr_done     = apb_done && pwrite;
  wire        rx_last     = cmd_bit_valid && rx_open && rx_cnt == `LAST_BIT;
  wire        crc_ok      = rx_crc == 8'h00;
  wire        addr_ok     = cmd.phys_addr_field == address_config_register;
  wire        is_read     = cmd.cmd_code == `CMD_READ;
  wire        is_write    = cmd.cmd_code == `CMD_WRITE;
  wire        is_periodic_collection_mode     = cmd.cmd_code == `CMD_PERIODIC_COLLECTION_MODE;
  wire        bad_crc     = rx_done && !crc_ok;
  wire        accept      = rx_done && crc_ok && addr_ok && state == ST_IDLE
                            && (is_read || is_write || is_periodic_collection_mode);
  wire [7:0]  wr_addr     = cmd.extended_data_field;
  wire        wr_inrange  = int'(wr_addr) < MEM_DEPTH;
  wire [7:0]  ra_next     = register_byte_address + 8'h01;
  wire        lo_readable = int'(register_byte_address) < MEM_DEPTH;
  wire        hi_readable = int'(ra_next) < MEM_DEPTH;
  wire        tx_data_on  = tx_cmd != `CMD_PERIODIC_COLLECTION_MODE;
  wire [7:0]  next_tx_crc = crc_step(tx_crc, tx_frame[`LAST_BIT - tx_cnt], resp_poly_register);
  wire        chip_tick   = chip_div == 8'(CHIP_CYCLES - 1);
  wire [5:0]  cur_sym     = symbol_of(tx_frame[31:28]);
  wire [1:0]  cur_chip    = chip_idx == 2'd0 ? cur_sym[5:4] :
                            chip_idx == 2'd1 ? cur_sym[3:2] : cur_sym[1:0];
  wire [31:0] status_word = {20'h0, tx_cmd, 5'h0, state != ST_IDLE,
                             periodic_collection_mode, crc_err_sticky};
  wire [31:0] rd_mux      = sel_addr   ? {28'h0, address_config_register} :
                            sel_cpoly  ? {24'h0, cmd_poly_register} :
                            sel_rpoly  ? {24'h0, resp_poly_register} :
                            sel_status ? status_word : 32'h0;

  // upper byte at address plus one; unreadable registers and code b responses read as zero.
  assign resp.phys_addr_field          = address_config_register;
  assign resp.cmd_code                 = tx_cmd;
  assign resp.next_register_data_field = (tx_data_on && hi_readable) ?
                                         mem[ra_next[$clog2(MEM_DEPTH)-1:0]] : 8'h00;
  assign resp.register_data_field      = (tx_data_on && lo_readable) ?
                                         mem[register_byte_address[$clog2(MEM_DEPTH)-1:0]] : 8'h00;
  assign resp.crc                      = 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready <= apb_acc;
      if (apb_acc) begin
        pslverr <= !mapped;
        prdata  <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_config_register <= `ADDR_CFG_RST;
      cmd_poly_register       <= `CRC_POLY_DEF;
      resp_poly_register      <= `CRC_POLY_DEF;
    end else if (wr_done) begin
      if (sel_addr) address_config_register <= pwdata[3:0];
      if (sel_cpoly) cmd_poly_register <= pwdata[7:0];
      if (sel_rpoly) resp_poly_register <= pwdata[7:0];
    end
  end

  // nonzero remainder flags an error; a new failure wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_err_sticky           <= 1'b0;
      crc_error                <= 1'b0;
      periodic_collection_mode <= 1'b0;
    end else begin
      crc_error <= bad_crc;
      if (bad_crc) crc_err_sticky <= 1'b1;
      else if (wr_done && sel_status && pwdata[`STAT_CRC_ERR]) crc_err_sticky <= 1'b0;
      if (accept && is_periodic_collection_mode) periodic_collection_mode <= 1'b1;
      else if (wr_done && sel_status && pwdata[`STAT_PERIODIC_COLLECTION_MODE]) periodic_collection_mode <= 1'b0;
    end
  end

  // serial check, all-ones seed before each command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame <= 32'h0;
      rx_crc   <= `CRC_SEED;
      rx_cnt   <= 5'd0;
      rx_open  <= 1'b0;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= rx_last;
      if (cmd_start) begin
        rx_crc  <= `CRC_SEED;
        rx_cnt  <= 5'd0;
        rx_open <= 1'b1;
      end else if (cmd_bit_valid && rx_open) begin
        rx_frame <= {rx_frame[30:0], cmd_bit};
        rx_crc   <= crc_step(rx_crc, cmd_bit, cmd_poly_register);
        rx_cnt   <= rx_cnt + 5'd1;
        rx_open  <= !rx_last;
      end
    end
  end

  // register write executes only on an accepted command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MEM_DEPTH; i++) mem[i] <= 8'h00;
    end else if (accept && is_write && wr_inrange) begin
      mem[wr_addr[$clog2(MEM_DEPTH)-1:0]] <= cmd.register_data_field;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                 <= ST_IDLE;
      tx_cmd                <= `CMD_READ;
      register_byte_address <= 8'h00;
      tx_frame              <= 32'h0;
      tx_crc                <= `CRC_SEED;
      tx_cnt                <= 5'd0;
      nib_idx               <= 3'd0;
      chip_idx              <= 2'd0;
      chip_div              <= 8'h00;
    end else begin
      unique case (state)
        // only own-address commands with good CRC proceed.
        ST_IDLE: if (accept) begin
          tx_cmd                <= cmd.cmd_code;
          register_byte_address <= cmd.extended_data_field;
          state                 <= ST_LOAD;
        end
        // response layout; written memory is already visible here.
        ST_LOAD: begin
          tx_frame <= resp;
          tx_crc   <= `CRC_SEED;
          tx_cnt   <= 5'd0;
          state    <= ST_CRC;
        end
        // message bits then eight zeros from the cleared CRC byte.
        ST_CRC: begin
          tx_crc <= next_tx_crc;
          tx_cnt <= tx_cnt + 5'd1;
          if (tx_cnt == `LAST_BIT) begin
            tx_frame[7:0] <= next_tx_crc;
            nib_idx       <= 3'd0;
            chip_idx      <= 2'd0;
            chip_div      <= 8'h00;
            state         <= ST_SEND;
          end
        end
        // three chips per nibble, top nibble first.
        ST_SEND: begin
          chip_div <= chip_tick ? 8'h00 : chip_div + 8'h01;
          if (chip_tick) begin
            chip_idx <= chip_idx == `LAST_CHIP ? 2'd0 : chip_idx + 2'd1;
            if (chip_idx == `LAST_CHIP) begin
              tx_frame <= {tx_frame[27:0], 4'h0};
              nib_idx  <= nib_idx + 3'd1;
              if (nib_idx == `LAST_NIBBLE) state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // level drive follows the symbol table one cycle late.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_level  <= 2'd0;
      resp_active <= 1'b0;
    end else begin
      chip_level  <= state == ST_SEND ? cur_chip : 2'd0;
      resp_active <= state == ST_SEND;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_seed;
    cmd_start |=> rx_crc == `CRC_SEED;
  endproperty
  a_seed: assert property (p_seed) else $error("CRC seed not preset");
  property p_crc_flag;
    rx_done && rx_crc != 8'h00 |=> crc_error;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("CRC failure not flagged");
  property p_no_answer;
    rx_done && rx_crc != 8'h00 && state == ST_IDLE |=> state == ST_IDLE;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("bad command answered");
  property p_addr_match;
    state == ST_LOAD |-> $past(addr_ok);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("foreign address accepted");
  property p_global_ignored;
    rx_done && cmd.phys_addr_field == `GLOBAL_ADDR && address_config_register != `GLOBAL_ADDR
      |=> state != ST_LOAD;
  endproperty
  a_global_ignored: assert property (p_global_ignored) else $error("global read answered");
  property p_crc_length;
    state == ST_LOAD |-> ##33 state == ST_SEND;
  endproperty
  a_crc_length: assert property (p_crc_length) else $error("CRC pass length wrong");
  property p_echo;
    state == ST_SEND && $past(state) == ST_CRC |-> tx_frame[27:24] == tx_cmd
      && tx_frame[31:28] == address_config_register;
  endproperty
  a_echo: assert property (p_echo) else $error("address or code echo wrong");
  property p_level_range;
    chip_level != 2'd3 && (resp_active || chip_level == 2'd0);
  endproperty
  a_level_range: assert property (p_level_range) else $error("illegal chip level");
  property p_first_chip;
    $rose(resp_active) |-> chip_level != 2'd0;
  endproperty
  a_first_chip: assert property (p_first_chip) else $error("packet starts quiescent");

  c_read: cover property (accept && is_read);
  c_write: cover property (accept && is_write);
  c_bad_crc: cover property (bad_crc);
  c_sent: cover property ($fell(resp_active));

endmodule // crm_command_response_framer

`default_nettype wire

//--- src/crm_framer_regs.svh
// Register offsets, field positions, reset values and codes of the response framer.
// Assumes APB byte addresses of 12 bits and 32-bit data words.
`ifndef CRM_FRAMER_REGS_SVH
`define CRM_FRAMER_REGS_SVH
`define OFS_ADDR_CFG   12'h000
`define OFS_CMD_POLY   12'h004
`define OFS_RESP_POLY  12'h008
`define OFS_STATUS     12'h00c
`define CRC_SEED       8'hff
`define CRC_POLY_DEF   8'h2f
`define ADDR_CFG_RST   4'h0
`define CMD_READ       4'h0
`define CMD_WRITE      4'h8
`define CMD_PERIODIC_COLLECTION_MODE       4'hb
`define GLOBAL_ADDR    4'h0
`define LAST_BIT       5'd31
`define LAST_NIBBLE    3'd7
`define LAST_CHIP      2'd2
`define STAT_CRC_ERR   0
`define STAT_PERIODIC_COLLECTION_MODE      1
`define STAT_BUSY      2
`define STAT_CMD_LSB   8
`define CHIP_CYCLES_DEF 8
`define MEM_DEPTH_DEF  16
`endif

//--- src/crm_framer_pkg.sv
// Types shared by the command and response framer.
// Assumes the constants header is included by the design file.
package crm_framer_pkg;
  typedef struct packed {
    logic [3:0] phys_addr_field;
    logic [3:0] cmd_code;
    logic [7:0] extended_data_field;
    logic [7:0] register_data_field;
    logic [7:0] crc;
  } cmd_frame_t;

  typedef struct packed {
    logic [3:0] phys_addr_field;
    logic [3:0] cmd_code;
    logic [7:0] next_register_data_field;
    logic [7:0] register_data_field;
    logic [7:0] crc;
  } resp_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_CRC  = 2'b10,
    ST_SEND = 2'b11
  } tx_state_t;
endpackage

//--- testbench/dsi3_master_model.sv
// Behavioural bus master that sends command words to the framer and records its chips.
// Assumes a single pclk domain; it sends one bit every second cycle.
`timescale 1ns/1ns
`default_nettype none
module dsi3_master_model (
  input  wire logic       pclk,
  input  wire logic [1:0] chip_level,
  input  wire logic       resp_active,
  output var  logic       cmd_start,
  output var  logic       cmd_bit,
  output var  logic       cmd_bit_valid
);
  logic [1:0] samples [$];
  initial begin
    cmd_start     = 1'b0;
    cmd_bit       = 1'b0;
    cmd_bit_valid = 1'b0;
  end
  task automatic send(input logic [31:0] frame);
    samples.delete();
    @(posedge pclk);
    cmd_start <= 1'b1;
    @(posedge pclk);
    cmd_start <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      cmd_bit_valid <= 1'b1;
      cmd_bit       <= frame[i];
      @(posedge pclk);
      cmd_bit_valid <= 1'b0;
      // The line shows the inverse once the bit is no longer valid.
      cmd_bit       <= ~frame[i];
      @(posedge pclk);
    end
  endtask
  always @(posedge pclk) begin
    if (resp_active === 1'b1) begin
      samples.push_back(chip_level);
    end
  end
endmodule // dsi3_master_model
`default_nettype wire

//--- testbench/crm_command_response_framer_tb.sv
// Self-checking bench for the command and response framer.
// Assumes the master model drives the command link; APB is driven here.
`timescale 1ns/1ns
`default_nettype none
`include "crm_framer_regs.svh"
module crm_command_response_framer_tb
  import crm_framer_pkg::*;
;
  localparam int CC = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cmd_start, cmd_bit_valid, cmd_bit, resp_active, crc_error, periodic_collection_mode;
  logic [1:0]  chip_level;
  logic [7:0]  cpoly, rpoly;
  int          fail_count = 0;
  int          checks = 0;
  int          err_pulses = 0;
  logic [5:0]  sym [16] = '{6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26, 6'h16, 6'h21,
                            6'h28, 6'h24, 6'h1a, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};

  crm_command_response_framer #(.CHIP_CYCLES(CC), .MEM_DEPTH(16)) u_crm_command_response_framer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_start(cmd_start), .cmd_bit_valid(cmd_bit_valid), .cmd_bit(cmd_bit),
    .chip_level(chip_level), .resp_active(resp_active), .crc_error(crc_error),
    .periodic_collection_mode(periodic_collection_mode));
  dsi3_master_model u_dsi3_master_model (
    .pclk(pclk), .chip_level(chip_level), .resp_active(resp_active),
    .cmd_start(cmd_start), .cmd_bit(cmd_bit), .cmd_bit_valid(cmd_bit_valid));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (crc_error === 1'b1) begin
      err_pulses++;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] msg, input logic [7:0] poly);
    logic [7:0]  c;
    logic [31:0] m;
    c = 8'hff;
    m = {msg, 8'h00};
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], m[i]} ^ (c[7] ? poly : 8'h00);
    end
    return c;
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic reg_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd & m, exp);
  endtask
  task automatic do_cmd(input logic [3:0] a, input logic [3:0] c, input logic [15:0] d,
                        input logic bad, input logic ans, input logic [15:0] rdat);
    cmd_frame_t  f;
    resp_frame_t r;
    int          n, e0, k;
    logic [3:0]  nib;
    logic [1:0]  seen, expc;
    f = {a, c, d, 8'h00};
    f.crc = crc8(f[31:8], cpoly) ^ {7'h00, bad};
    r = {4'h5, c, rdat, 8'h00};
    r.crc = crc8(r[31:8], rpoly);
    e0 = err_pulses;
    n = 0;
    u_dsi3_master_model.send(f);
    while (resp_active !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    if (ans && resp_active !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    while (resp_active === 1'b1 && n < 250) begin
      @(posedge pclk);
      n++;
    end
    if (resp_active === 1'b1) begin
      fail_count++;
      print_verdict();
    end
    repeat (2) @(posedge pclk);
    check("crc error pulses", 32'(err_pulses - e0), {31'h0, bad});
    check("chip count", 32'(u_dsi3_master_model.samples.size()), ans ? 24 * CC : 0);
    for (int i = 0; i < 24 * CC && i < u_dsi3_master_model.samples.size(); i++) begin
      k = i / CC;
      nib = r[31 - 4 * (k / 3) -: 4];
      seen = u_dsi3_master_model.samples[i];
      expc = sym[nib][5 - 2 * (k % 3) -: 2];
      check("chip", {30'h0, seen}, {30'h0, expc});
    end
    check("idle level", {30'h0, chip_level}, 32'h0);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpoly = `CRC_POLY_DEF;
    rpoly = `CRC_POLY_DEF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reg_chk(`OFS_ADDR_CFG, 32'hffffffff, 32'h0);
    reg_chk(`OFS_CMD_POLY, 32'hffffffff, 32'h2f);
    reg_chk(`OFS_RESP_POLY, 32'hffffffff, 32'h2f);
    reg_chk(`OFS_STATUS, 32'hffffffff, 32'h0);
    apb(1'b1, 12'h010, 32'h5);
    check("slave error", {31'h0, err}, 32'h1);
    reg_chk(12'h010, 32'hffffffff, 32'h0);
    apb(1'b1, `OFS_ADDR_CFG, 32'h5);
    reg_chk(`OFS_ADDR_CFG, 32'hffffffff, 32'h5);
    do_cmd(4'h5, `CMD_WRITE, 16'h035a, 1'b0, 1'b1, 16'h005a);
    do_cmd(4'h5, `CMD_WRITE, 16'h04c3, 1'b0, 1'b1, 16'h00c3);
    do_cmd(4'h5, `CMD_READ, 16'h0300, 1'b0, 1'b1, 16'hc35a);
    do_cmd(4'h3, `CMD_READ, 16'h0300, 1'b0, 1'b0, 16'h0);
    do_cmd(`GLOBAL_ADDR, `CMD_READ, 16'h0300, 1'b0, 1'b0, 16'h0);
    do_cmd(4'h5, `CMD_READ, 16'h0300, 1'b1, 1'b0, 16'h0);
    reg_chk(`OFS_STATUS, 32'h1, 32'h1);
    apb(1'b1, `OFS_STATUS, 32'h1);
    reg_chk(`OFS_STATUS, 32'h1, 32'h0);
    for (int c = 0; c < 16; c++) begin
      do_cmd(4'h5, 4'(c), 16'h1477, 1'b0, c == 0 || c == 8 || c == 11, 16'h0);
    end
    check("periodic mode", {31'h0, periodic_collection_mode}, 32'h1);
    reg_chk(`OFS_STATUS, 32'h00000f03, 32'h00000b02);
    apb(1'b1, `OFS_CMD_POLY, 32'h07);
    apb(1'b1, `OFS_RESP_POLY, 32'h1d);
    cpoly = 8'h07;
    rpoly = 8'h1d;
    do_cmd(4'h5, `CMD_READ, 16'h0300, 1'b0, 1'b1, 16'hc35a);
    print_verdict();
  end
endmodule // crm_command_response_framer_tb
`default_nettype wire
